/* File: verilog/solution_flow_controller.sv */
// solution flow controller: decides when each solution actuator runs and
// exposes configuration and operator requests over axi4-lite.
// assumes switches and pedal pins are asynchronous and the dashboard
// requests are written into the operator register by software.
//
// Overview of operation
// RULE1: tank-first mode runs recovered pump only while clean tank is empty.
// RULE2: any-time mode ignores the clean tank empty switch.
// RULE3: recovered scrubbing only while recovery float switch is open.
// RULE4: recovered scrubbing needs option installed, enabled, request, pedal.
// RULE5: recovered scrubbing stops clean pump, runs recovered pump, keeps soap.
// RULE6: main flow needs request, pedal out of neutral, tank not empty.
// RULE7: main valve is on/off; clean pump pwm follows flow rate.
// RULE8: right side valve opens together with the main valve.
// RULE9: right valve needs side option, main and side request, pedal.
// RULE10: detergent cycle extends forward for 80 ms.
// RULE11: then retracts reversed for 50 ms, then dwells off.
// RULE12: pumps alternate with an interval gap; zero means immediate.
// RULE13: interval comes from a table by flow rate and ratio.
// RULE14: detergent needs option, request and pedal out of neutral.
// RULE15: mist pump needs option, broom request and pedal out of neutral.
// RULE16: with recovered option fitted, mist stops when clean tank runs dry.
// RULE17: a configuration bit allows main flow while reversing.
// RULE18: outputs drop at once when a condition fails; cycles abort.
`timescale 1ns/1ns
`default_nettype none
module solution_flow_controller
    import flow_pkg::*;
#(
    parameter int RW = RATE_W
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // machine inputs, asynchronous
    input  wire logic        clean_tank_empty_switch,
    input  wire logic        recovery_float_switch,
    input  wire logic        pedal_position_sensor,
    input  wire logic        pedal_reverse,
    // actuator outputs
    output logic             main_flow_valve,
    output logic             right_side_flow_valve,
    output logic             clean_solution_pump,
    output logic             solution_pump_pwm_output,
    output logic             recovered_water_pump,
    output logic             broom_mist_pump,
    output logic [1:0]       detergent_pump_a,
    output logic [1:0]       detergent_pump_b
);

    localparam int unsigned SW = $bits(sense_t);

    // registers
    logic [CFG_W-1:0]  cfg_r;
    logic [OPER_W-1:0] oper_r;
    logic [SW-1:0]     sync1_r;
    logic [SW-1:0]     sync2_r;
    sense_t            sense;
    drive_t            drive_nxt;
    drive_t            drive_r;

    // bus state
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;

    // two flops on every pin input; only the second stage is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {clean_tank_empty_switch, recovery_float_switch,
                        pedal_position_sensor, pedal_reverse};
            sync2_r <= sync1_r;
        end
    end
    assign sense = sense_t'(sync2_r);

    // millisecond enable from a divider
    localparam int DIVW = $clog2(CYC_PER_MS);
    logic [DIVW-1:0] div_r;
    logic            ms_tick;
    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign ms_tick = (div_r == DIVW'(CYC_PER_MS - 1));

    // permission logic
    logic pedal_ok;
    logic request;
    logic recov_active;
    logic main_active;
    logic side_ok;
    logic det_run;
    logic mist_ok;
    logic src_ok;

    always_comb begin
        // reverse travel may be barred for main flow only
        pedal_ok = sense.pedal_active;
        request  = oper_r[OPER_SCRUB_SOL];
        // tank-first waits for an empty clean tank; any-time ignores it
        src_ok   = cfg_r[CFG_ANY_TIME] | sense.tank_empty; // RULE1 RULE2
        recov_active = cfg_r[CFG_RECOV_INST] & cfg_r[CFG_RECOV_EN] // RULE4
                     & request & pedal_ok
                     & ~sense.float_closed                   // RULE3
                     & src_ok;
        main_active  = request & pedal_ok & ~sense.tank_empty // RULE6
                     & (cfg_r[CFG_REVERSE_OK]
                        | ~sense.pedal_reverse);             // RULE17
        side_ok      = cfg_r[CFG_SIDE_INST] & cfg_r[CFG_SIDE_EN]
                     & request & oper_r[OPER_SIDE_SCRUB]
                     & pedal_ok;                             // RULE9
        det_run      = cfg_r[CFG_DET_INST] & cfg_r[CFG_DET_EN]
                     & request & pedal_ok;                   // RULE14 RULE5
        mist_ok      = cfg_r[CFG_MIST_INST] & cfg_r[CFG_MIST_EN]
                     & oper_r[OPER_BROOM] & pedal_ok         // RULE15
                     & ~(cfg_r[CFG_RECOV_INST]
                         & sense.tank_empty);                // RULE16
        drive_nxt.main_valve = main_active | recov_active;   // RULE7
        drive_nxt.side_valve = (main_active | recov_active)
                             & side_ok;                      // RULE8
        drive_nxt.clean_pump = main_active & ~recov_active;  // RULE5
        drive_nxt.recov_pump = recov_active;                 // RULE5
        drive_nxt.mist_pump  = mist_ok;
    end

    // outputs registered; any failing condition drops them next edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt; // RULE18
        end
    end
    assign main_flow_valve       = drive_r.main_valve;
    assign right_side_flow_valve = drive_r.side_valve;
    assign clean_solution_pump   = drive_r.clean_pump;
    assign recovered_water_pump  = drive_r.recov_pump;
    assign broom_mist_pump       = drive_r.mist_pump;

    // pwm: duty grows with the selected rate; rate 0 gives zero duty
    logic [PWM_W-1:0] pwm_cnt_r;
    logic [PWM_W-1:0] duty;
    logic             pwm_r;
    assign duty = PWM_W'(oper_r[OPER_RATE_LSB +: RW]) * PWM_STEP;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_cnt_r <= '0;
            pwm_r     <= 1'b0;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 1'b1;
            pwm_r     <= drive_nxt.clean_pump
                       & (pwm_cnt_r < duty); // RULE7
        end
    end
    assign solution_pump_pwm_output = pwm_r;

    // interval lookup by rate and ratio
    logic              lut_we;
    logic [LUT_DW-1:0] interval_ms;
    assign lut_we = wr_fire && (awaddr_r == LUT_OFS);
    interval_table #(
        .AW (LUT_AW),
        .DW (LUT_DW)
    ) u_table (
        .aclk    (aclk),
        .wr_en   (lut_we),
        .wr_addr (wdata_r[LUT_ADDR_LSB +: LUT_AW]),
        .wr_data (wdata_r[LUT_DW-1:0]),
        .rd_addr ({oper_r[OPER_RATE_LSB +: RW],
                   oper_r[OPER_RATIO_LSB +: RATIO_W]}), // RULE13
        .rd_data (interval_ms)
    );

    // detergent sequencer
    logic [1:0] det_fwd;
    logic [1:0] det_rev;
    detergent_cycler #(
        .DW (LUT_DW)
    ) u_cycler (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ms_tick     (ms_tick),
        .interval_ms (interval_ms),
        .run         (det_run),
        .pump_fwd    (det_fwd),
        .pump_rev    (det_rev)
    );
    assign detergent_pump_a = {det_rev[0], det_fwd[0]};
    assign detergent_pump_b = {det_rev[1], det_fwd[1]};

    // axi4-lite write path: address and data in either order
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign wr_fire = aw_hold_r & w_hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    // register stores; only the low two byte lanes carry bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r  <= CFG_RST;
            oper_r <= OPER_RST;
        end else if (wr_fire) begin
            if (awaddr_r == CFG_OFS) begin
                if (wstrb_r[0]) cfg_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) cfg_r[CFG_W-1:8] <= wdata_r[CFG_W-1:8];
            end
            if (awaddr_r == OPER_OFS) begin
                if (wstrb_r[0]) oper_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) oper_r[OPER_W-1:8] <= wdata_r[OPER_W-1:8];
            end
        end
    end

    // write response; unmapped or read-only offsets get slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == CFG_OFS || awaddr_r == OPER_OFS
                             || awaddr_r == LUT_OFS) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read path: one cycle to rvalid
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                CFG_OFS:    s_axi_rdata <= 32'(cfg_r);
                OPER_OFS:   s_axi_rdata <= 32'(oper_r);
                INPUT_OFS:  s_axi_rdata <= 32'(sync2_r);
                OUTPUT_OFS: s_axi_rdata <= 32'({det_rev, det_fwd,
                                                drive_r});
                LUT_OFS:    s_axi_rdata <= 32'(interval_ms);
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: verilog/flow_pkg.sv */
// package for the solution flow controller: register map, field layout,
// reset values and timing constants shared by all design files.
// assumes a 100 MHz clock and 32-bit axi4-lite register access.
`default_nettype none
package flow_pkg;

    // clock rate and derived millisecond enable
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / MS_PER_S;

    // detergent pump phase times, in ms
    localparam int unsigned EXTEND_MS      = 80;
    localparam int unsigned RETRACT_MS     = 50;

    // register byte offsets
    localparam logic [7:0] CFG_OFS         = 8'h00;
    localparam logic [7:0] OPER_OFS        = 8'h04;
    localparam logic [7:0] INPUT_OFS       = 8'h08;
    localparam logic [7:0] OUTPUT_OFS      = 8'h0c;
    localparam logic [7:0] LUT_OFS         = 8'h10;

    // configuration register bits
    localparam int CFG_RECOV_INST          = 0;
    localparam int CFG_RECOV_EN            = 1;
    localparam int CFG_ANY_TIME            = 2;
    localparam int CFG_SIDE_INST           = 3;
    localparam int CFG_SIDE_EN             = 4;
    localparam int CFG_DET_INST            = 5;
    localparam int CFG_DET_EN              = 6;
    localparam int CFG_MIST_INST           = 7;
    localparam int CFG_MIST_EN             = 8;
    localparam int CFG_REVERSE_OK          = 9;
    localparam int CFG_W                   = 10;
    localparam logic [CFG_W-1:0] CFG_RST   = 10'h000;

    // operator register fields, as relayed from the dashboard
    localparam int OPER_SCRUB_SOL          = 0;
    localparam int OPER_SIDE_SCRUB         = 1;
    localparam int OPER_BROOM              = 2;
    localparam int OPER_RATE_LSB           = 4;
    localparam int OPER_RATIO_LSB          = 8;
    localparam int RATE_W                  = 3;
    localparam int RATIO_W                 = 2;
    localparam int OPER_W                  = 10;
    localparam logic [OPER_W-1:0] OPER_RST = 10'h000;

    // interval lookup: one entry per rate and ratio, in ms
    localparam int LUT_AW                  = RATE_W + RATIO_W;
    localparam int LUT_DW                  = 12;
    localparam int LUT_ADDR_LSB            = 16;

    // pwm: 9 high counts of 64 per rate step
    localparam int PWM_W                   = 6;
    localparam logic [PWM_W-1:0] PWM_STEP  = 6'h09;

    // axi responses
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    // sampled machine inputs travel together
    typedef struct packed {
        logic tank_empty;     // clean_tank_empty_switch closed
        logic float_closed;   // recovery_float_switch closed
        logic pedal_active;   // out of neutral
        logic pedal_reverse;  // travelling in reverse
    } sense_t;

    // actuator outputs travel together
    typedef struct packed {
        logic main_valve;
        logic side_valve;
        logic clean_pump;
        logic recov_pump;
        logic mist_pump;
    } drive_t;

endpackage
`default_nettype wire

/* File: verilog/interval_table.sv */
// interval lookup memory: one word per flow rate and detergent ratio.
// assumes the write port is driven by the register slave on the same clock.
`timescale 1ns/1ns
`default_nettype none
module interval_table
    import flow_pkg::*;
#(
    parameter int AW = LUT_AW,
    parameter int DW = LUT_DW
) (
    // clock
    input  wire logic          aclk,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read side, registered
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [2**AW];

    // no reset on the array so it maps to block or distributed ram
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule
`default_nettype wire

/* File: verilog/detergent_cycler.sv */
// alternating two-pump detergent sequencer: extend, retract, dwell, then
// the other pump after the interval. assumes a 1 ms enable pulse.
`timescale 1ns/1ns
`default_nettype none
module detergent_cycler
    import flow_pkg::*;
#(
    parameter int DW = LUT_DW
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // timing
    input  wire logic          ms_tick,
    input  wire logic [DW-1:0] interval_ms,
    // permission
    input  wire logic          run,
    // pump drive: fwd extends, rev retracts
    output logic      [1:0]    pump_fwd,
    output logic      [1:0]    pump_rev
);

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_EXTEND  = 4'b0010,
        ST_RETRACT = 4'b0100,
        ST_GAP     = 4'b1000
    } det_state_t;

    det_state_t    state_r;
    logic [DW-1:0] cnt_r;
    logic          sel_r;

    // sequencer; dropping run aborts at once with both pumps off
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            state_r <= ST_IDLE; // RULE18
            cnt_r   <= '0;
            sel_r   <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_EXTEND;
                    cnt_r   <= '0;
                end
                ST_EXTEND: if (ms_tick) begin
                    if (cnt_r == DW'(EXTEND_MS - 1)) begin // RULE10
                        state_r <= ST_RETRACT;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_RETRACT: if (ms_tick) begin
                    if (cnt_r == DW'(RETRACT_MS - 1)) begin // RULE11
                        sel_r <= ~sel_r; // RULE12
                        cnt_r <= '0;
                        // zero interval starts the other pump at once
                        state_r <= (interval_ms == '0) ? ST_EXTEND : ST_GAP;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_GAP: if (ms_tick) begin
                    if (cnt_r + 1'b1 >= interval_ms) begin // RULE12
                        state_r <= ST_EXTEND;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // idle pump dwells off while the other one runs
    always_comb begin
        pump_fwd = 2'b00;
        pump_rev = 2'b00;
        if (state_r == ST_EXTEND) begin
            pump_fwd[sel_r] = run; // RULE10
        end
        if (state_r == ST_RETRACT) begin
            pump_rev[sel_r] = run; // RULE11
        end
    end

endmodule
`default_nettype wire

/* File: test/flow_chk.sv */
// assertions on the actuator outputs of the solution flow controller.
// assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module flow_chk (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // machine pins
    input wire logic       clean_tank_empty_switch,
    input wire logic       recovery_float_switch,
    input wire logic       pedal_position_sensor,
    // actuators
    input wire logic       main_flow_valve,
    input wire logic       right_side_flow_valve,
    input wire logic       clean_solution_pump,
    input wire logic       recovered_water_pump,
    input wire logic       broom_mist_pump,
    input wire logic [1:0] detergent_pump_a,
    input wire logic [1:0] detergent_pump_b
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // pins take three edges to reach outputs, so hold them four
    sequence pedal_idle;
        !pedal_position_sensor [*4];
    endsequence
    sequence tank_dry;
        clean_tank_empty_switch [*4];
    endsequence
    sequence float_low;
        recovery_float_switch [*4];
    endsequence
    AST_MAIN_PEDAL: assert property (pedal_idle |-> !main_flow_valve)
        else $error("main valve open in neutral");
    AST_MAIN_TANK: assert property (tank_dry |-> !clean_solution_pump)
        else $error("clean pump on with tank empty");
    AST_RECOV_FLOAT: assert property (
        float_low |-> !recovered_water_pump)
        else $error("recovered pump on with float closed");
    AST_RECOV_EXCL: assert property (
        !(recovered_water_pump && clean_solution_pump))
        else $error("both solution pumps on");
    AST_SIDE_MAIN: assert property (
        right_side_flow_valve |-> main_flow_valve)
        else $error("side valve open without main valve");
    AST_MIST_PEDAL: assert property (pedal_idle |-> !broom_mist_pump)
        else $error("mist pump on in neutral");
    AST_DET_PEDAL: assert property (pedal_idle |->
        detergent_pump_a == 2'h0 && detergent_pump_b == 2'h0)
        else $error("detergent pump driven in neutral");
    AST_DET_POL: assert property (
        !(&detergent_pump_a) && !(&detergent_pump_b))
        else $error("detergent pump driven both ways");
    AST_DET_ALT: assert property (
        !(|detergent_pump_a && |detergent_pump_b))
        else $error("both detergent pumps driven");
endmodule
bind solution_flow_controller flow_chk chk (
    .aclk, .aresetn, .clean_tank_empty_switch, .recovery_float_switch,
    .pedal_position_sensor, .main_flow_valve, .right_side_flow_valve,
    .clean_solution_pump, .recovered_water_pump, .broom_mist_pump,
    .detergent_pump_a, .detergent_pump_b
);
`default_nettype wire

/* File: test/machine_side.sv */
// model of the machine side: pedal sensor, tank and float switches.
// assumes the bench sets the wanted levels by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module machine_side
    import flow_pkg::*;
(
    // clock
    input  wire logic   aclk,
    // wanted levels
    input  wire sense_t want,
    // pins toward the controller
    output logic        clean_tank_empty_switch,
    output logic        recovery_float_switch,
    output logic        pedal_position_sensor,
    output logic        pedal_reverse
);
    // contacts move just after an edge, never in step with the sampler
    always_ff @(posedge aclk) begin
        clean_tank_empty_switch <= want.tank_empty;
        recovery_float_switch   <= want.float_closed;
        pedal_position_sensor   <= want.pedal_active;
        pedal_reverse           <= want.pedal_reverse;
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench: axi4-lite tasks, pin scenarios, pwm and table.
// assumes a 100 MHz clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import flow_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdv, cnt;
    logic        clean_tank_empty_switch, recovery_float_switch;
    logic        pedal_position_sensor, pedal_reverse;
    logic        main_flow_valve, right_side_flow_valve;
    logic        clean_solution_pump, solution_pump_pwm_output;
    logic        recovered_water_pump, broom_mist_pump;
    logic [1:0]  detergent_pump_a, detergent_pump_b;
    sense_t      want = 4'h0;
    int          err_total = 0, n_tests = 0;

    always #5 aclk = ~aclk;

    machine_side ms (.aclk, .want, .clean_tank_empty_switch,
        .recovery_float_switch, .pedal_position_sensor, .pedal_reverse);
    solution_flow_controller dut (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data go out together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_left = 1'b1, w_left = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && s_axi_awready) begin
                aw_left = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_left && s_axi_wready) begin
                w_left = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // expected e = {main, side, clean, recov, mist, pump a, pump b}
    task automatic scn(input logic [9:0] c, input logic [9:0] o,
                       input sense_t p, input logic [8:0] e);
        wr(CFG_OFS, {22'h0, c});
        wr(OPER_OFS, {22'h0, o});
        want <= p;
        repeat (6) @(posedge aclk);
        chk({23'h0, main_flow_valve, right_side_flow_valve,
             clean_solution_pump, recovered_water_pump, broom_mist_pump,
             detergent_pump_a, detergent_pump_b}, {23'h0, e});
    endtask

    task automatic results;
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // 20000 cycles is twelve times the run
    initial begin
        #200_000;
        err_total++;
        results();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CFG_OFS);
        chk(rdv, 32'h0);
        rd(OPER_OFS);
        chk(rdv, 32'h0);
        rd(8'h20);
        chk({rdv[31:2], resp}, {30'h0, RESP_SLVERR});
        wr(INPUT_OFS, 32'h0000_000f);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(CFG_OFS, 32'h0000_03ff);
        rd(CFG_OFS);
        chk(rdv, 32'h0000_03ff);
        scn(10'h000, 10'h001, 4'h2, 9'h140);
        scn(10'h000, 10'h001, 4'h0, 9'h000);
        scn(10'h000, 10'h001, 4'ha, 9'h000);
        rd(INPUT_OFS);
        chk(rdv, 32'h0000_000a);
        scn(10'h000, 10'h001, 4'h3, 9'h000);
        scn(10'h200, 10'h001, 4'h3, 9'h140);
        scn(10'h018, 10'h003, 4'h2, 9'h1c0);
        scn(10'h018, 10'h001, 4'h2, 9'h140);
        scn(10'h008, 10'h003, 4'h2, 9'h140);
        scn(10'h018, 10'h002, 4'h2, 9'h000);
        scn(10'h003, 10'h001, 4'ha, 9'h120);
        scn(10'h003, 10'h001, 4'h2, 9'h140);
        scn(10'h003, 10'h001, 4'he, 9'h000);
        scn(10'h007, 10'h001, 4'h2, 9'h120);
        scn(10'h001, 10'h001, 4'ha, 9'h000);
        scn(10'h002, 10'h001, 4'ha, 9'h000);
        scn(10'h007, 10'h000, 4'h2, 9'h000);
        scn(10'h180, 10'h004, 4'h2, 9'h010);
        scn(10'h180, 10'h004, 4'h0, 9'h000);
        scn(10'h100, 10'h004, 4'h2, 9'h000);
        scn(10'h181, 10'h004, 4'ha, 9'h000);
        scn(10'h180, 10'h004, 4'ha, 9'h010);
        scn(10'h063, 10'h001, 4'ha, 9'h124);
        scn(10'h060, 10'h001, 4'h2, 9'h144);
        rd(OUTPUT_OFS);
        chk(rdv, 32'h0000_0034);
        scn(10'h060, 10'h001, 4'h0, 9'h000);
        scn(10'h020, 10'h001, 4'h2, 9'h140);
        // table entry i holds i + 1 ms
        for (int i = 0; i < 32; i++)
            wr(LUT_OFS, {11'h0, i[4:0], 4'h0, i[11:0] + 12'h001});
        scn(10'h000, 10'h001, 4'h2, 9'h140);
        // every rate code, ratio taken from the low rate bits
        for (int r = 0; r < 8; r++) begin
            wr(OPER_OFS, {22'h0, r[1:0], 1'b0, r[2:0], 4'h1});
            repeat (70) @(posedge aclk);
            cnt = 32'h0;
            repeat (64) begin
                @(posedge aclk);
                cnt = cnt + {31'h0, solution_pump_pwm_output};
            end
            chk(cnt, r * 9);
            rd(LUT_OFS);
            chk(rdv, r * 4 + r % 4 + 1);
        end
        results();
    end
endmodule
`default_nettype wire
